// ===== design/regv_map.svh
/*
  Register offsets, field positions, reset values and timing figures for the
  regulator voltage configuration bank.
  Assumes it is included by bare name from design files that need it.
*/
`ifndef REGV_MAP_SVH
`define REGV_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the two-wire interface)
// ----------------------------------------------------------------------------
`define REGV_OFF_CH1_SEL        8'h02
`define REGV_OFF_CH23_SEL       8'h03
`define REGV_OFF_CH4_SEL        8'h04
`define REGV_OFF_SCALE_CFG      8'h05

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define REGV_CH1_CODE_MSB       4
`define REGV_CH1_CODE_LSB       0
`define REGV_CH2_CODE_MSB       2
`define REGV_CH2_CODE_LSB       0
`define REGV_CH3_CODE_MSB       6
`define REGV_CH3_CODE_LSB       4
`define REGV_CH4_CODE_MSB       4
`define REGV_CH4_CODE_LSB       0
`define REGV_CH4_EN_BIT         6
`define REGV_CH4_INT_MSB        5
`define REGV_CH4_INT_LSB        4
`define REGV_CH1_EN_BIT         2
`define REGV_CH1_INT_MSB        1
`define REGV_CH1_INT_LSB        0

// ----------------------------------------------------------------------------
// Reset values of the bits that do not come from fuses
// ----------------------------------------------------------------------------
`define REGV_SCALE_CFG_RESET    8'h00
`define REGV_RSVD3_RESET        3'h0
`define REGV_RSVD1_RESET        1'h0
`define REGV_UNMAPPED_READ      8'h00

// ----------------------------------------------------------------------------
// Timing: step intervals in tenths of a microsecond, clock period in ns
// ----------------------------------------------------------------------------
`define REGV_CLK_PERIOD_NS      5
`define REGV_STEP_T0_US_X10     625
`define REGV_STEP_T1_US_X10     312
`define REGV_STEP_T2_US_X10     156
`define REGV_STEP_T3_US_X10     78
`define REGV_CYCLES(t)          (((t) * 100) / `REGV_CLK_PERIOD_NS)

`endif

// ===== design/regv_pkg.sv
/*
  Types shared by the regulator voltage configuration bank.
  Assumes nothing of its surroundings.
*/
package regv_pkg;

  // --------------------------------------------------------------------------
  // Two-wire slave states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    REGV_IDLE,
    REGV_ADDR,
    REGV_ADDR_ACK,
    REGV_PTR,
    REGV_PTR_ACK,
    REGV_WDATA,
    REGV_WDATA_ACK,
    REGV_RDATA,
    REGV_RDATA_ACK
  } regv_i2c_state_t;

  typedef logic [7:0] regv_byte_t;

endpackage

// ===== design/regv_stepper.sv
/*
  Stepped voltage scaling for one channel: moves the applied select code one
  count per step interval toward the target code while scaling is enabled.
  Assumes target, enable and interval come from registers on the same clock.
*/
module regv_stepper
  import regv_pkg::*;
#(
  parameter int W  = 5,
  parameter int CW = 14,
  parameter int C0 = 12500,
  parameter int C1 = 6240,
  parameter int C2 = 3120,
  parameter int C3 = 1560
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Settings
  input  wire logic [W-1:0] reset_code_i,
  input  wire logic [W-1:0] target_i,
  input  wire logic         enable_i,
  input  wire logic [1:0]   interval_i,
  // Applied code
  output logic      [W-1:0] applied_o
);

  logic [CW-1:0] tick_cnt;
  logic [CW-1:0] tick_limit;

  // --------------------------------------------------------------------------
  // Interval selection
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (interval_i)
      2'b00: tick_limit = CW'(C0 - 1);
      2'b01: tick_limit = CW'(C1 - 1);
      2'b10: tick_limit = CW'(C2 - 1);
      2'b11: tick_limit = CW'(C3 - 1);
    endcase
  end

  // --------------------------------------------------------------------------
  // Stepping
  // --------------------------------------------------------------------------
  // The count compares with >= so that shortening the interval mid-ramp does
  // not make the counter run past its limit and wrap around.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      applied_o <= reset_code_i;
      tick_cnt  <= '0;
    end else if (!enable_i) begin
      applied_o <= target_i;
      tick_cnt  <= '0;
    end else if (applied_o == target_i) begin
      tick_cnt  <= '0;
    end else if (tick_cnt >= tick_limit) begin
      tick_cnt  <= '0;
      if (applied_o < target_i) begin
        applied_o <= applied_o + W'(1);
      end else begin
        applied_o <= applied_o - W'(1);
      end
    end else begin
      tick_cnt  <= tick_cnt + CW'(1);
    end
  end

endmodule

// ===== design/regv_top.sv
/*
  Regulator voltage configuration bank: channel 1 to 4 select codes and the
  stepped voltage scaling settings of channels 1 and 4, reached by a host over
  a two-wire serial slave, with the scaling sequencer for channels 1 and 4.
  Assumes fuse inputs are static levels from logic on clk_i, the serial pins
  are asynchronous, and reset_i is the internal supply power-on reset.
*/
// Overview of operation
// R1: Channel 1 code is bits 4..0; code 00000 is adjustable mode with 0.8 V reference.
// R2: Channel 1 codes map to fixed voltages; 11111 gives 1.6 V.
// R3: All select fields load fuse inputs at reset; host may overwrite later.
// R4: Channel 3 code is bits 6..4; 000 adjustable, 001..111 give 1.2..1.8 V.
// R5: Channel 2 code is bits 2..0; 000 adjustable, up to 111 giving 5.0 V.
// R6: Channel 4 code is bits 4..0; 00000 adjustable, 11111 gives 5.5 V.
// R7: Bits 7 and 3 of channel 2/3 register are stored but ignored.
// R8: Scaling config bit 6 enables channel 4 stepping; resets to zero.
// R9: Bits 5..4 pick channel 4 step interval, 62.5 us down to 7.8 us.
// R10: Scaling config bit 2 enables channel 1 stepping; resets to zero.
// R11: Bits 1..0 pick channel 1 step interval with the channel 4 encoding.
// R12: Registers return to defaults only while the power-on reset is asserted.
// R13: Host configures the registers over the two-wire serial interface.
// R14: With scaling on, applied code steps one count per interval to target.
// R15: Every code value is stored and read back exactly as written.
`include "regv_map.svh"

module regv_top
  import regv_pkg::*;
#(
  // Arbitrary value; set to the bus address the system assigns.
  parameter logic [6:0] DEV_ADDR     = 7'h2A,
  parameter int         STEP_CYC_0   = `REGV_CYCLES(`REGV_STEP_T0_US_X10),
  parameter int         STEP_CYC_1   = `REGV_CYCLES(`REGV_STEP_T1_US_X10),
  parameter int         STEP_CYC_2   = `REGV_CYCLES(`REGV_STEP_T2_US_X10),
  parameter int         STEP_CYC_3   = `REGV_CYCLES(`REGV_STEP_T3_US_X10),
  parameter int         STEP_CNT_W   = 14
) (
  // Clock and power-on reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Two-wire serial pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Factory fuse defaults
  input  wire logic [4:0] fuse_ch1_code_i,
  input  wire logic [2:0] fuse_ch2_code_i,
  input  wire logic [2:0] fuse_ch3_code_i,
  input  wire logic [4:0] fuse_ch4_code_i,
  // Codes applied to the regulator references
  output logic      [4:0] ch1_voltage_code_o,
  output logic      [2:0] ch2_voltage_code_o,
  output logic      [2:0] ch3_voltage_code_o,
  output logic      [4:0] ch4_voltage_code_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  regv_byte_t      ch1_voltage_select;
  regv_byte_t      ch2_ch3_voltage_select;
  regv_byte_t      ch4_voltage_select;
  regv_byte_t      voltage_scaling_config;

  logic            scl_s1;
  logic            scl_s2;
  logic            scl_d;
  logic            sda_s1;
  logic            sda_s2;
  logic            sda_d;
  logic            scl_rise;
  logic            scl_fall;
  logic            bus_start;
  logic            bus_stop;

  regv_i2c_state_t state;
  logic [3:0]      bit_cnt;
  regv_byte_t      shift;
  regv_byte_t      tx;
  regv_byte_t      ptr;
  logic            rw;
  logic            master_nack;
  logic            wr_strobe;
  regv_byte_t      wr_addr;
  regv_byte_t      wr_data;
  regv_byte_t      rd_byte;

  // --------------------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // --------------------------------------------------------------------------
  // Lines idle high, so the synchronisers reset high to avoid a false start.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // --------------------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (ptr)
      `REGV_OFF_CH1_SEL:   rd_byte = ch1_voltage_select;      // see R15
      `REGV_OFF_CH23_SEL:  rd_byte = ch2_ch3_voltage_select;  // see R7
      `REGV_OFF_CH4_SEL:   rd_byte = ch4_voltage_select;
      `REGV_OFF_SCALE_CFG: rd_byte = voltage_scaling_config;
      default:             rd_byte = `REGV_UNMAPPED_READ;
    endcase
  end

  // --------------------------------------------------------------------------
  // Two-wire slave
  // --------------------------------------------------------------------------
  // The slave never stretches the clock; it acknowledges a matching address and every byte written after it,
  // including those aimed at unmapped offsets, which are simply dropped.
  // The data pin is open drain: the output is held low and only its enable
  // moves, so a one on the wire is always the pull-up's doing.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state       <= REGV_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      tx          <= 8'h00;
      ptr         <= 8'h00;
      rw          <= 1'b0;
      master_nack <= 1'b0;
      sda_oe_o    <= 1'b0;
      wr_strobe   <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (bus_start) begin                                    // see R13
        state    <= REGV_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        state    <= REGV_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (state)
          REGV_IDLE: begin
            bit_cnt <= 4'h0;
          end
          REGV_ADDR, REGV_PTR, REGV_WDATA: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shift   <= {shift[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == REGV_ADDR) begin
                if (shift[7:1] == DEV_ADDR) begin
                  rw       <= shift[0];
                  sda_oe_o <= 1'b1;
                  state    <= REGV_ADDR_ACK;
                end else begin
                  state    <= REGV_IDLE;
                end
              end else if (state == REGV_PTR) begin
                ptr      <= shift;
                sda_oe_o <= 1'b1;
                state    <= REGV_PTR_ACK;
              end else begin
                wr_strobe <= 1'b1;                            // see R13
                wr_addr   <= ptr;
                wr_data   <= shift;
                sda_oe_o  <= 1'b1;
                state     <= REGV_WDATA_ACK;
              end
            end
          end
          REGV_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw) begin
                tx       <= rd_byte;
                sda_oe_o <= ~rd_byte[7];
                state    <= REGV_RDATA;
              end else begin
                sda_oe_o <= 1'b0;
                state    <= REGV_PTR;
              end
            end
          end
          REGV_PTR_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              state    <= REGV_WDATA;
            end
          end
          REGV_WDATA_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              ptr      <= ptr + 8'h01;
              state    <= REGV_WDATA;
            end
          end
          REGV_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe_o <= 1'b0;
                bit_cnt  <= 4'h0;
                ptr      <= ptr + 8'h01;
                state    <= REGV_RDATA_ACK;
              end else begin
                tx       <= {tx[6:0], 1'b0};
                sda_oe_o <= ~tx[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          REGV_RDATA_ACK: begin
            if (scl_rise) begin
              master_nack <= sda_s2;
            end else if (scl_fall) begin
              if (!master_nack) begin
                tx       <= rd_byte;
                sda_oe_o <= ~rd_byte[7];
                state    <= REGV_RDATA;
              end else begin
                state    <= REGV_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Reserved bits are plain storage so the host reads back what it wrote.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin                                        // see R12
      ch1_voltage_select     <= {`REGV_RSVD3_RESET, fuse_ch1_code_i};  // see R3
      ch2_ch3_voltage_select <= {`REGV_RSVD1_RESET, fuse_ch3_code_i,
                                 `REGV_RSVD1_RESET, fuse_ch2_code_i};  // see R3
      ch4_voltage_select     <= {`REGV_RSVD3_RESET, fuse_ch4_code_i};  // see R3
      voltage_scaling_config <= `REGV_SCALE_CFG_RESET;        // see R8
    end else if (wr_strobe) begin
      unique case (wr_addr)
        `REGV_OFF_CH1_SEL:   ch1_voltage_select     <= wr_data;  // see R15
        `REGV_OFF_CH23_SEL:  ch2_ch3_voltage_select <= wr_data;  // see R15
        `REGV_OFF_CH4_SEL:   ch4_voltage_select     <= wr_data;  // see R15
        `REGV_OFF_SCALE_CFG: voltage_scaling_config <= wr_data;  // see R10
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Applied codes
  // --------------------------------------------------------------------------
  // Channels 2 and 3 have no scaling and follow their fields directly; the
  // reserved bits 7 and 3 never reach them.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ch2_voltage_code_o <= fuse_ch2_code_i;
      ch3_voltage_code_o <= fuse_ch3_code_i;
    end else begin
      ch2_voltage_code_o <= ch2_ch3_voltage_select[`REGV_CH2_CODE_MSB:`REGV_CH2_CODE_LSB];  // see R5, R7
      ch3_voltage_code_o <= ch2_ch3_voltage_select[`REGV_CH3_CODE_MSB:`REGV_CH3_CODE_LSB];  // see R4, R7
    end
  end

  // Code 00000 on channels 1 and 4 is adjustable mode; the reference decodes
  // every code, so stepping passes through the intermediate voltages.
  regv_stepper #(
    .W  (5),
    .CW (STEP_CNT_W),
    .C0 (STEP_CYC_0),
    .C1 (STEP_CYC_1),
    .C2 (STEP_CYC_2),
    .C3 (STEP_CYC_3)
  ) u_ch1_step (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .reset_code_i (fuse_ch1_code_i),
    .target_i     (ch1_voltage_select[`REGV_CH1_CODE_MSB:`REGV_CH1_CODE_LSB]),       // see R1, R2
    .enable_i     (voltage_scaling_config[`REGV_CH1_EN_BIT]),                        // see R10, R14
    .interval_i   (voltage_scaling_config[`REGV_CH1_INT_MSB:`REGV_CH1_INT_LSB]),     // see R11
    .applied_o    (ch1_voltage_code_o)
  );

  regv_stepper #(
    .W  (5),
    .CW (STEP_CNT_W),
    .C0 (STEP_CYC_0),
    .C1 (STEP_CYC_1),
    .C2 (STEP_CYC_2),
    .C3 (STEP_CYC_3)
  ) u_ch4_step (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .reset_code_i (fuse_ch4_code_i),
    .target_i     (ch4_voltage_select[`REGV_CH4_CODE_MSB:`REGV_CH4_CODE_LSB]),       // see R6
    .enable_i     (voltage_scaling_config[`REGV_CH4_EN_BIT]),                        // see R8, R14
    .interval_i   (voltage_scaling_config[`REGV_CH4_INT_MSB:`REGV_CH4_INT_LSB]),     // see R9
    .applied_o    (ch4_voltage_code_o)
  );

endmodule

// ===== verif/regv_top_monitor.sv
/*
  Port checker for regv_top.
  Assumes every step interval in use is 5 clock cycles or longer.
*/
module regv_top_monitor (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // Serial data pin
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // Fuses and codes
  input wire logic [4:0] fuse_ch1_code_i,
  input wire logic [2:0] fuse_ch2_code_i,
  input wire logic [2:0] fuse_ch3_code_i,
  input wire logic [4:0] fuse_ch4_code_i,
  input wire logic [4:0] ch1_voltage_code_o,
  input wire logic [2:0] ch2_voltage_code_o,
  input wire logic [2:0] ch3_voltage_code_o,
  input wire logic [4:0] ch4_voltage_code_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------
  // Checks
  // ------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda_o driven high");

  property p_fuse_14;
    $fell(reset_i) |-> ch1_voltage_code_o == fuse_ch1_code_i && ch4_voltage_code_o == fuse_ch4_code_i;
  endproperty
  a_fuse_14: assert property (p_fuse_14)
    else $error("ch1 or ch4 code not from fuses after reset");

  property p_fuse_23;
    $fell(reset_i) |-> ch2_voltage_code_o == fuse_ch2_code_i && ch3_voltage_code_o == fuse_ch3_code_i;
  endproperty
  a_fuse_23: assert property (p_fuse_23)
    else $error("ch2 or ch3 code not from fuses after reset");

  property p_idle_after_reset;
    $fell(reset_i) |-> !sda_oe_o;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("sda driven right after reset");

  // Channel 2 and 3 codes only move as the result of a host write, whose ack holds the pin.
  property p_ch23_by_write;
    ($changed(ch2_voltage_code_o) || $changed(ch3_voltage_code_o)) |-> $past(sda_oe_o);
  endproperty
  a_ch23_by_write: assert property (p_ch23_by_write)
    else $error("ch2 or ch3 code moved without a write");

  property p_ch1_unit_step;
    ($changed(ch1_voltage_code_o) && !$past(sda_oe_o)) |->
      (ch1_voltage_code_o == $past(ch1_voltage_code_o) + 5'h1 ||
       ch1_voltage_code_o == $past(ch1_voltage_code_o) - 5'h1);
  endproperty
  a_ch1_unit_step: assert property (p_ch1_unit_step)
    else $error("ch1 step larger than one count");

  property p_ch4_unit_step;
    ($changed(ch4_voltage_code_o) && !$past(sda_oe_o)) |->
      (ch4_voltage_code_o == $past(ch4_voltage_code_o) + 5'h1 ||
       ch4_voltage_code_o == $past(ch4_voltage_code_o) - 5'h1);
  endproperty
  a_ch4_unit_step: assert property (p_ch4_unit_step)
    else $error("ch4 step larger than one count");

  property p_ch1_spacing;
    ($changed(ch1_voltage_code_o) && !$past(sda_oe_o)) |=>
      (!$changed(ch1_voltage_code_o) || $past(sda_oe_o))[*4];
  endproperty
  a_ch1_spacing: assert property (p_ch1_spacing)
    else $error("ch1 steps closer than the shortest interval");
endmodule

// ===== verif/regv_host.sv
/*
  Two-wire host model: START, STOP, bytes and acknowledges, MSB first.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
module regv_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Bus pins
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quarter bit time in ns; raising it makes a slow host.
  int q = 25;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Data changes only while the clock is low and is sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    #q scl_o = 1'b1;
    #q r = sda_i;
    #q scl_o = 1'b0;
    #q;
  endtask

  task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    #q scl_o = 1'b1;
    #q sda_low_o = 1'b1;
    #q scl_o = 1'b0;
    #q;
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    #q scl_o = 1'b1;
    #q sda_low_o = 1'b0;
    #q;
  endtask

  task automatic head(input logic [6:0] a, input logic [7:0] ptr, output logic ack);
    logic [7:0] r;
    logic       n0;
    logic       n1;
    start();
    byte_io({a, 1'b0}, r);
    bit_io(1'b1, n0);
    byte_io(ptr, r);
    bit_io(1'b1, n1);
    ack = ~(n0 | n1);
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic       n;
    head(a, ptr, ack);
    byte_io(d, r);
    bit_io(1'b1, n);
    stop();
    ack = ack & ~n;
  endtask

  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic ack;
    logic n;
    head(DEV_ADDR, ptr, ack);
    start();
    byte_io({DEV_ADDR, 1'b1}, d);
    bit_io(1'b1, n);
    byte_io(8'hFF, d);
    bit_io(1'b1, n);
    stop();
  endtask
endmodule

// ===== verif/test_regulator_voltage_config_regs.sv
/*
  Self-checking bench for regv_top with a two-wire host model.
  Assumes shortened step intervals of 40, 20, 10 and 5 cycles.
*/
module test_regulator_voltage_config_regs
  import regv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    regv_byte_t ptr, wd, rb;
    logic [4:0] c1;
    logic [2:0] c2, c3;
    logic [4:0] c4;
  } regv_row_t;

  localparam logic [6:0] ADDR = 7'h2A;
  localparam int CYC [4] = '{40, 20, 10, 5};
  localparam regv_row_t ROWS [10] = '{
    '{8'h02, 8'hFF, 8'hFF, 5'h1F, 3'h5, 3'h6, 5'h1A}, '{8'h02, 8'hE0, 8'hE0, 5'h00, 3'h5, 3'h6, 5'h1A},
    '{8'h03, 8'h88, 8'h88, 5'h00, 3'h0, 3'h0, 5'h1A}, '{8'h03, 8'h77, 8'h77, 5'h00, 3'h7, 3'h7, 5'h1A},
    '{8'h03, 8'h1A, 8'h1A, 5'h00, 3'h2, 3'h1, 5'h1A}, '{8'h03, 8'h9A, 8'h9A, 5'h00, 3'h2, 3'h1, 5'h1A},
    '{8'h04, 8'hFF, 8'hFF, 5'h00, 3'h2, 3'h1, 5'h1F}, '{8'h04, 8'hE1, 8'hE1, 5'h00, 3'h2, 3'h1, 5'h01},
    '{8'h05, 8'h88, 8'h88, 5'h00, 3'h2, 3'h1, 5'h01}, '{8'h07, 8'h5A, 8'h00, 5'h00, 3'h2, 3'h1, 5'h01}};

  logic       clk_i;
  logic       reset_i = 1'b1;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe_o;
  wire logic  sda = ~(sda_oe_o | sda_low);
  logic [4:0] f1 = 5'h13;
  logic [2:0] f2 = 3'h5;
  logic [2:0] f3 = 3'h6;
  logic [4:0] f4 = 5'h1A;
  logic [4:0] c1, c4;
  logic [2:0] c2, c3;
  regv_byte_t rd;
  logic       ack;
  int         n;
  int         n_errors = 0;
  int         check_count = 0;

  regv_top #(.DEV_ADDR(ADDR), .STEP_CYC_0(CYC[0]), .STEP_CYC_1(CYC[1]), .STEP_CYC_2(CYC[2]),
    .STEP_CYC_3(CYC[3])) u_dut (.clk_i, .reset_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o,
    .fuse_ch1_code_i(f1), .fuse_ch2_code_i(f2), .fuse_ch3_code_i(f3), .fuse_ch4_code_i(f4),
    .ch1_voltage_code_o(c1), .ch2_voltage_code_o(c2), .ch3_voltage_code_o(c3), .ch4_voltage_code_o(c4));
  regv_host #(.DEV_ADDR(ADDR)) u_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic codes(input logic [4:0] e1, input logic [2:0] e2, e3, input logic [4:0] e4);
    chk("ch1 code", 8'(e1), 8'(c1));
    chk("ch2 code", 8'(e2), 8'(c2));
    chk("ch3 code", 8'(e3), 8'(c3));
    chk("ch4 code", 8'(e4), 8'(c4));
  endtask

  task automatic rd_chk(input regv_byte_t ptr, input regv_byte_t exp);
    u_host.rd_reg(ptr, rd);
    chk("read back", exp, rd);
  endtask

  task automatic wr(input regv_byte_t ptr, input regv_byte_t d);
    u_host.wr_reg(ADDR, ptr, d, ack);
    chk("ack", 8'h01, 8'(ack));
  endtask

  task automatic do_reset(input logic [4:0] a, input logic [2:0] b, c, input logic [4:0] d);
    @(posedge clk_i);
    #1 {f1, f2, f3, f4, reset_i} = {a, b, c, d, 1'b1};
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge clk_i);
    // Host moves and output checks stay 1 ns clear of the sampling edge.
    #1 codes(a, b, c, d);
    rd_chk(8'h02, {3'h0, a});
    rd_chk(8'h03, {1'b0, c, 1'b0, b});
    rd_chk(8'h04, {3'h0, d});
    rd_chk(8'h05, 8'h00);
  endtask

  // The second count is the spacing of two consecutive steps.
  task automatic gap(input bit ch4, output int cnt);
    logic [4:0] prev;
    for (int k = 0; k < 2; k++) begin
      prev = ch4 ? c4 : c1;
      cnt = 0;
      while ((ch4 ? c4 : c1) === prev && cnt < 400) begin
        @(posedge clk_i);
        #1 cnt++;
      end
      if (cnt >= 400) begin
        chk("step seen", 8'h01, 8'h00);
        summarize();
      end
    end
  endtask

  // ------------------
  // Main sequence
  // ------------------
  initial begin
    do_reset(5'h13, 3'h5, 3'h6, 5'h1A);
    foreach (ROWS[i]) begin
      wr(ROWS[i].ptr, ROWS[i].wd);
      rd_chk(ROWS[i].ptr, ROWS[i].rb);
      codes(ROWS[i].c1, ROWS[i].c2, ROWS[i].c3, ROWS[i].c4);
    end
    u_host.q = 60;
    u_host.wr_reg(ADDR ^ 7'h01, 8'h04, 8'h0F, ack);
    chk("stray ack", 8'h00, 8'(ack));
    rd_chk(8'h04, 8'hE1);
    u_host.q = 25;
    for (int i = 0; i < 4; i++) begin
      wr(8'h05, {2'b01, 2'(i), 2'b01, 2'(i)});
      wr(8'h02, i[0] ? 8'h00 : 8'h1F);
      gap(1'b0, n);
      chk("ch1 interval", 8'(CYC[i]), 8'(n));
      wr(8'h04, i[0] ? 8'h00 : 8'h1F);
      gap(1'b1, n);
      chk("ch4 interval", 8'(CYC[i]), 8'(n));
    end
    wr(8'h05, 8'h44);
    wr(8'h02, 8'h1F);
    wr(8'h04, 8'h1F);
    chk("ch4 ramping", 8'h01, 8'(c4 < 5'h1F));
    wr(8'h05, 8'h00);
    codes(5'h1F, 3'h2, 3'h1, 5'h1F);
    do_reset(5'h0C, 3'h3, 3'h1, 5'h07);
    summarize();
  end
endmodule

bind regv_top regv_top_monitor u_mon (.clk_i, .reset_i, .sda_o, .sda_oe_o, .fuse_ch1_code_i,
  .fuse_ch2_code_i, .fuse_ch3_code_i, .fuse_ch4_code_i, .ch1_voltage_code_o, .ch2_voltage_code_o,
  .ch3_voltage_code_o, .ch4_voltage_code_o);
